// ==== hw/priority_interrupt_controller.sv ====
// eight-level priority interrupt controller with the condition flags
// assumes a sequencer on the same clock that presents its instruction
// status on machine-cycle enables and runs the short call on ack
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pic_regs.svh"

module priority_interrupt_controller #(
  parameter int LEVELS = `PIC_LEVELS,
  parameter int NSRC   = `PIC_SOURCES
) (
  input  wire logic                     CLK_SYS_I,   // core clock, 50 MHz
  input  wire logic                     RST_I,       // master reset, async high
  input  wire logic [`PIC_ADDR_W-1:0]   ADDR_I,      // I/O address
  input  wire logic [`PIC_DATA_W-1:0]   WDATA_I,     // I/O write nibble
  input  wire logic                     WR_I,        // write strobe
  input  wire logic                     RD_I,        // read strobe
  output logic      [`PIC_DATA_W-1:0]   RDATA_O,     // read nibble, next cycle
  input  wire logic [NSRC-1:0]          SRC_I,       // peripheral request pulses
  input  wire logic                     PIN60_I,     // external pin, any edge
  input  wire logic                     PIN61_I,     // external pin, any edge
  input  wire pic_pkg::cpu_req_t        CPU_I,       // sequencer status
  input  wire logic                     ALU_WE_I,    // alu updates branch/carry
  input  wire logic                     ALU_B_I,     // alu branch result
  input  wire logic                     ALU_C_I,     // alu carry result
  output logic                          MC_EN_O,     // machine-cycle enable
  output pic_pkg::ack_t                 ACK_O,       // acknowledge pulse
  output logic      [LEVELS-1:0]        PENDING_O,   // pending register
  output logic      [LEVELS-1:0]        ACTIVE_O,    // active register
  output logic      [3:0]               FLAGS_O      // condition_flags
);

  logic              mc_q;
  logic [LEVELS-1:0] pend_q, pend_d, act_q, act_d;
  logic [3:0]        flags_q, flags_d;
  logic [3:0]        ctrl_q [NSRC];
  logic [NSRC-1:0]   hold_q, hold_d, raw_req;
  logic [1:0]        p60_s, p61_s;
  logic              p60_old_q, p61_old_q;
  logic [3:0]        rdata_q;
  pic_pkg::ack_t     ack_q, ack_d;

  // machine-cycle divider
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) mc_q <= 1'b0;
    else       mc_q <= ~mc_q;
  end

  wire mc_en    = mc_q;
  wire step     = mc_en & CPU_I.instr_end;
  wire take_hw  = mc_en & ~CPU_I.io_instr;
  wire op_taken = step & (CPU_I.op != pic_pkg::OP_NONE);
  wire is_ret   = step & (CPU_I.op == pic_pkg::OP_RET_IRQ);
  wire en_set_op = op_taken & ((CPU_I.op == pic_pkg::OP_IRQ_ON) |
                               (CPU_I.op == pic_pkg::OP_RET_IRQ) |
                               (CPU_I.op == pic_pkg::OP_SLEEP));

  // pins cross from outside; only the second stage is looked at
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      p60_s     <= 2'h0;
      p61_s     <= 2'h0;
      p60_old_q <= 1'b0;
      p61_old_q <= 1'b0;
    end else begin
      p60_s     <= {p60_s[0], PIN60_I};
      p61_s     <= {p61_s[0], PIN61_I};
      p60_old_q <= p60_s[1];
      p61_old_q <= p61_s[1];
    end
  end

  wire p60_edge = p60_s[1] ^ p60_old_q;
  wire p61_edge = p61_s[1] ^ p61_old_q;

  // bus decode
  wire wr_pend_lo = WR_I & (ADDR_I == `PIC_A_PEND_LO);
  wire wr_pend_hi = WR_I & (ADDR_I == `PIC_A_PEND_HI);
  wire wr_flags   = WR_I & (ADDR_I == `PIC_A_FLAGS);
  wire in_ctrl    = ADDR_I[`PIC_A_CTRL_SEL];
  wire [2:0] ctrl_idx = ADDR_I[2:0];

  // per-source capture, mask and level routing
  logic [LEVELS-1:0] src_lvl [NSRC];
  logic [LEVELS-1:0] hw_set;

  for (genvar s = 0; s < NSRC; s++) begin : g_src
    wire [1:0] sel = ctrl_q[s][`PIC_C_LVL_HI:`PIC_C_LVL_LO];
    logic [2:0] lvl;
    always_comb begin
      case (s)
        `PIC_S_PORTA, `PIC_S_PORTB, `PIC_S_PIN60, `PIC_S_TMR0:
          lvl = {sel, 1'b1};
        `PIC_S_ITA: lvl = sel[0] ? 3'h5 : 3'h1;
        `PIC_S_ITB: lvl = sel[0] ? 3'h6 : 3'h2;
        default:    lvl = {sel, 1'b0};
      endcase
    end
    assign raw_req[s] = (s == `PIC_S_PIN60) ? p60_edge :
                        (s == `PIC_S_PIN61) ? p61_edge : SRC_I[s];
    // a request in an I/O cycle waits here for the next sample
    assign hold_d[s] = (hold_q[s] & ~take_hw) |
                       (raw_req[s] & ctrl_q[s][`PIC_C_ENABLE]);
    assign src_lvl[s] = (hold_q[s] & take_hw) ?
                        (LEVELS'(1) << lvl) : '0;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I)                       ctrl_q[s] <= `PIC_CTRL_RST;
      else if (WR_I & in_ctrl &
               (ctrl_idx == 3'(s)))    ctrl_q[s] <= WDATA_I;
    end
  end

  always_comb begin
    hw_set = '0;
    for (int s = 0; s < NSRC; s++) hw_set = hw_set | src_lvl[s];
  end

  // software requests set bits only, nibble by nibble
  wire [LEVELS-1:0] sw_set = {wr_pend_hi ? WDATA_I : 4'h0,
                              wr_pend_lo ? WDATA_I : 4'h0};

  function automatic logic [3:0] top_of(input logic [LEVELS-1:0] v);
    logic [3:0] t;
    t = 4'hF;
    for (int i = 0; i < LEVELS; i++)
      if (v[i]) t = 4'(i);
    return t;
  endfunction : top_of

  function automatic logic [11:0] vec_of(input logic [2:0] l);
    case (l)
      3'h0:    return `PIC_VEC0;
      3'h1:    return `PIC_VEC1;
      3'h2:    return `PIC_VEC2;
      3'h3:    return `PIC_VEC3;
      3'h4:    return `PIC_VEC4;
      3'h5:    return `PIC_VEC5;
      3'h6:    return `PIC_VEC6;
      default: return `PIC_VEC7;
    endcase
  endfunction : vec_of

  // 4'hF marks "none"; levels compare on bits 2:0 only, with act_q == '0 standing in for none
  wire [3:0] top_wait = top_of(pend_q & ~act_q);
  wire [3:0] top_act  = top_of(act_q);
  wire       have_wait = (pend_q & ~act_q) != '0;
  wire       above_act = (act_q == '0) || (top_wait[2:0] > top_act[2:0]);
  wire       irq_en    = flags_q[`PIC_F_IRQ_EN];
  wire       grant     = step & ~is_ret & irq_en & have_wait & above_act;
  wire [2:0] ret_lvl   = top_act[2:0];
  wire [LEVELS-1:0] ret_clr = (is_ret && act_q != '0) ?
                              (LEVELS'(1) << ret_lvl) : '0;
  wire [LEVELS-1:0] ack_set = grant ? (LEVELS'(1) << top_wait[2:0]) : '0;

  wire [LEVELS-1:0] pend_set = hw_set | sw_set;

  // new requests win over the clear of the same cycle
  assign pend_d = (pend_q & ~ret_clr) | hw_set | sw_set;
  assign act_d  = (act_q & ~ret_clr) | ack_set;

  always_comb begin
    ack_d        = '0;
    ack_d.valid  = grant;
    ack_d.level  = top_wait[2:0];
    ack_d.vector = grant ? vec_of(top_wait[2:0]) : '0;
  end

  // condition flags; a direct write may clear enable but never set it
  always_comb begin
    flags_d = flags_q;
    if (ALU_WE_I) begin
      flags_d[`PIC_F_BRANCH] = ALU_B_I;
      flags_d[`PIC_F_CARRY]  = ALU_C_I;
    end
    if (wr_flags) begin
      flags_d[`PIC_F_BRANCH] = WDATA_I[`PIC_F_BRANCH];
      flags_d[`PIC_F_CARRY]  = WDATA_I[`PIC_F_CARRY];
      flags_d[`PIC_F_IRQ_EN] = irq_en & WDATA_I[`PIC_F_IRQ_EN];
    end
    if (op_taken) begin
      case (CPU_I.op)
        pic_pkg::OP_IRQ_ON,
        pic_pkg::OP_RET_IRQ,
        pic_pkg::OP_SLEEP:   flags_d[`PIC_F_IRQ_EN] = 1'b1;
        pic_pkg::OP_IRQ_OFF: flags_d[`PIC_F_IRQ_EN] = 1'b0;
        pic_pkg::OP_SET_BCF: begin
          flags_d[`PIC_F_BRANCH] = 1'b1;
          flags_d[`PIC_F_CARRY]  = 1'b1;
        end
        pic_pkg::OP_TOG_BF:  flags_d[`PIC_F_BRANCH] = ~flags_q[`PIC_F_BRANCH];
        pic_pkg::OP_FLAGS_WR: begin
          flags_d[`PIC_F_BRANCH] = CPU_I.flags_wd[`PIC_F_BRANCH];
          flags_d[`PIC_F_CARRY]  = CPU_I.flags_wd[`PIC_F_CARRY];
          flags_d[`PIC_F_IRQ_EN] = irq_en & CPU_I.flags_wd[`PIC_F_IRQ_EN];
        end
        default: ;
      endcase
    end
    flags_d[3] = 1'b0;
  end

  // read mux on the 16 primary addresses
  logic [3:0] rd_mux;
  always_comb begin
    case (ADDR_I)
      `PIC_A_PEND_LO: rd_mux = pend_q[3:0];
      `PIC_A_PEND_HI: rd_mux = pend_q[7:4];
      `PIC_A_ACT_LO:  rd_mux = act_q[3:0];
      `PIC_A_ACT_HI:  rd_mux = act_q[7:4];
      `PIC_A_FLAGS:   rd_mux = flags_q;
      default:        rd_mux = in_ctrl ? ctrl_q[ctrl_idx] : 4'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pend_q  <= '0;
      act_q   <= '0;
      flags_q <= `PIC_FLAGS_RST;
      hold_q  <= '0;
      ack_q   <= '0;
      rdata_q <= 4'h0;
    end else begin
      pend_q  <= pend_d;
      act_q   <= act_d;
      flags_q <= flags_d;
      hold_q  <= hold_d;
      ack_q   <= ack_d;
      rdata_q <= RD_I ? rd_mux : 4'h0;
    end
  end

  assign RDATA_O   = rdata_q;
  assign MC_EN_O   = mc_q;
  assign ACK_O     = ack_q;
  assign PENDING_O = pend_q;
  assign ACTIVE_O  = act_q;
  assign FLAGS_O   = flags_q;

  // checks
  property p_mc_period;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      mc_q |=> !mc_q ##1 mc_q;
  endproperty
  a_mc_period: assert property (p_mc_period)
    else $error("machine cycle is not two clocks");

  property p_ack_gated;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ack_q.valid |-> $past(flags_q[`PIC_F_IRQ_EN]) && $past(mc_q);
  endproperty
  a_ack_gated: assert property (p_ack_gated)
    else $error("ack issued with enable clear");

  property p_ack_active;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ack_q.valid |-> act_q[ack_q.level] &&
                      (($past(act_q) & (LEVELS'(1) << ack_q.level)) == '0);
  endproperty
  a_ack_active: assert property (p_ack_active)
    else $error("active bit not set on ack");

  property p_ack_prio;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ack_q.valid |-> ($past(act_q) == '0) ||
                      (ack_q.level > $past(top_act[2:0]));
  endproperty
  a_ack_prio: assert property (p_ack_prio)
    else $error("ack below an active level");

  property p_ack_vector;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      // kept apart from the vector table: the lower seven are evenly spaced
      ack_q.valid |-> ack_q.vector == ((ack_q.level == 3'(`PIC_LEVELS - 1)) ? `PIC_VEC7 :
                                       12'(`PIC_VEC0 * (12'(ack_q.level) + 12'h001)));
  endproperty
  a_ack_vector: assert property (p_ack_vector)
    else $error("wrong vector for level");

  property p_ret_clear;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (is_ret && act_q != '0) |=> !act_q[$past(ret_lvl)] && flags_q[`PIC_F_IRQ_EN];
  endproperty
  a_ret_clear: assert property (p_ret_clear)
    else $error("return left level active or enable clear");

  property p_irq_off;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (step && CPU_I.op == pic_pkg::OP_IRQ_OFF) |=>
        !flags_q[`PIC_F_IRQ_EN] ##1 !ack_q.valid;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("enable not cleared by irq_off");

  property p_io_hold;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (!take_hw && !WR_I && !is_ret) |=> pend_q == $past(pend_q);
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("pending changed outside a sample cycle");

  property p_grant;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (step && !is_ret && irq_en && have_wait && above_act) |=> ack_q.valid;
  endproperty
  a_grant: assert property (p_grant)
    else $error("eligible request not acknowledged");

  property p_reset_clear;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $fell(RST_I) |-> (pend_q == '0) && (act_q == '0) && !irq_en;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not clear after reset");

  property p_ack_pulse;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ack_q.valid |=> !ack_q.valid;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  // ack must not retire the request, so a repeat stays absorbed
  property p_ack_pend;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ack_q.valid |-> pend_q[ack_q.level];
  endproperty
  a_ack_pend: assert property (p_ack_pend)
    else $error("pending bit dropped at ack");

  // the edge that releases reset still samples it high: skip that one
  property p_act_rise;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      !RST_I |-> (act_q & ~$past(act_q)) == $past(ack_set);
  endproperty
  a_act_rise: assert property (p_act_rise)
    else $error("active bit set outside an ack");

  property p_pend_keep;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      !RST_I |-> (($past(pend_q) & ~pend_q) & ~$past(ret_clr)) == '0;
  endproperty
  a_pend_keep: assert property (p_pend_keep)
    else $error("pending bit lost without a return");

  property p_ret_pend;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (is_ret && act_q != '0) |=> (pend_q & ~$past(pend_set) & $past(ret_clr)) == '0;
  endproperty
  a_ret_pend: assert property (p_ret_pend)
    else $error("return left serviced level pending");

  property p_en_set;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(irq_en) |-> $past(en_set_op);
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable set by other than on, return or sleep");

  property p_sw_set;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      wr_pend_hi |=> (pend_q[7:4] & $past(WDATA_I)) == $past(WDATA_I);
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("soft request not recorded in pending");

endmodule : priority_interrupt_controller

// ==== hw/pic_regs.svh ====
// register offsets, field positions, reset values and timing counts of the
// priority interrupt controller; assumes a 4-bit address, 4-bit data I/O port
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// 16 primary I/O addresses
`define PIC_ADDR_W        4
`define PIC_DATA_W        4
`define PIC_A_PEND_LO     4'h0
`define PIC_A_PEND_HI     4'h1
`define PIC_A_ACT_LO      4'h2
`define PIC_A_ACT_HI      4'h3
`define PIC_A_FLAGS       4'h4
`define PIC_A_CTRL_BASE   4'h8
`define PIC_A_CTRL_SEL    3

// condition_flags layout
`define PIC_F_IRQ_EN      0
`define PIC_F_BRANCH      1
`define PIC_F_CARRY       2
`define PIC_FLAGS_RST     4'h0

// per-source control nibble layout
`define PIC_C_ENABLE      3
`define PIC_C_LVL_HI      1
`define PIC_C_LVL_LO      0
`define PIC_CTRL_RST      4'h0

// levels and vectors
`define PIC_LEVELS        8
`define PIC_SOURCES       8
`define PIC_VEC_W         12
`define PIC_VEC0          12'h040
`define PIC_VEC1          12'h080
`define PIC_VEC2          12'h0C0
`define PIC_VEC3          12'h100
`define PIC_VEC4          12'h140
`define PIC_VEC5          12'h180
`define PIC_VEC6          12'h1C0
`define PIC_VEC7          12'h1E0

// source indices
`define PIC_S_PORTA       0
`define PIC_S_PORTB       1
`define PIC_S_PIN60       2
`define PIC_S_PIN61       3
`define PIC_S_ITA         4
`define PIC_S_ITB         5
`define PIC_S_TMR0        6
`define PIC_S_TMR1        7

// one machine cycle is this many core_clock cycles
`define PIC_MC_CLKS       2

`endif

// ==== hw/pic_pkg.sv ====
// types shared by the interrupt controller and its sequencer partner
// assumes the register constants of pic_regs.svh
package pic_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_IRQ_ON,
    OP_IRQ_OFF,
    OP_RET_IRQ,
    OP_SLEEP,
    OP_SET_BCF,
    OP_TOG_BF,
    OP_FLAGS_WR
  } cpu_op_t;

  typedef struct packed {
    logic       instr_end;
    logic       io_instr;
    cpu_op_t    op;
    logic [3:0] flags_wd;
  } cpu_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  level;
    logic [11:0] vector;
  } ack_t;

endpackage : pic_pkg

// ==== dv/seq_model.sv ====
// sequencer stand-in: ends an instruction every len_i+1 machine cycles
// assumes the controller's machine-cycle enable on the same clock
`timescale 1ns/1ps
module seq_model (
  input  wire logic             clk_i,   // core clock
  input  wire logic             rst_i,   // master reset
  input  wire logic             mc_en_i, // machine-cycle enable
  input  wire pic_pkg::cpu_op_t op_i,    // op for the next instruction end
  input  wire logic [1:0]       len_i,   // instruction length minus one
  input  wire logic             io_i,    // i/o instruction running
  input  wire logic [3:0]       wd_i,    // flags write value
  output pic_pkg::cpu_req_t     req_o,   // status to the controller
  output logic                  taken_o  // op consumed at last edge
);
  logic [1:0] cnt_q;
  logic       last;
  assign last = (cnt_q == len_i);
  // 1 to 4 machine cycles per instruction
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= 2'h0;
      taken_o <= 1'b0;
    end else begin
      taken_o <= mc_en_i & last;
      if (mc_en_i) begin
        cnt_q <= last ? 2'h0 : cnt_q + 2'h1;
      end
    end
  end
  // op only at an instruction end; the ack call itself is the core's
  assign req_o = '{instr_end: last, io_instr: io_i,
                   op: last ? op_i : pic_pkg::OP_NONE, flags_wd: wd_i};
endmodule : seq_model

// ==== dv/priority_interrupt_controller_tb.sv ====
// bench of the priority interrupt controller: soft, hardware and flag traffic
// assumes seq_model stands in for the sequencer on the same clock
`timescale 1ns/1ps
`include "pic_regs.svh"
module priority_interrupt_controller_tb;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [3:0]        addr = 4'h0;
  logic [3:0]        wdata = 4'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [7:0]        src = 8'h00;
  logic              p60 = 1'b0;
  logic              p61 = 1'b0;
  logic              alu_we = 1'b0;
  logic              alu_c = 1'b0;
  pic_pkg::cpu_op_t  op = pic_pkg::OP_NONE;
  logic [1:0]        len = 2'h0;
  logic              io = 1'b0;
  logic [3:0]        rdata;
  logic              mc_en;
  logic              taken;
  pic_pkg::cpu_req_t cpu;
  pic_pkg::ack_t     ack;
  logic [7:0]        pend;
  logic [7:0]        act;
  logic [3:0]        flags;
  int                num_errors = 0;
  int                compares = 0;
  int                acks = 0;
  integer            seed = 32'hCC53AB13;
  logic [11:0]       vtab [8] = '{12'h040, 12'h080, 12'h0C0, 12'h100,
                                  12'h140, 12'h180, 12'h1C0, 12'h1E0};
  pic_pkg::cpu_op_t  fop [7] = '{pic_pkg::OP_TOG_BF, pic_pkg::OP_IRQ_ON, pic_pkg::OP_IRQ_OFF,
                                 pic_pkg::OP_SLEEP, pic_pkg::OP_IRQ_OFF, pic_pkg::OP_FLAGS_WR,
                                 pic_pkg::OP_SET_BCF};
  logic [3:0]        fexp [7] = '{4'h4, 4'h5, 4'h4, 4'h5, 4'h4, 4'h2, 4'h6};

  priority_interrupt_controller DUT (
    .CLK_SYS_I(clk),
    .RST_I(rst),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .SRC_I(src),
    .PIN60_I(p60),
    .PIN61_I(p61),
    .CPU_I(cpu),
    .ALU_WE_I(alu_we),
    .ALU_B_I(~alu_c),
    .ALU_C_I(alu_c),
    .MC_EN_O(mc_en),
    .ACK_O(ack),
    .PENDING_O(pend),
    .ACTIVE_O(act),
    .FLAGS_O(flags)
  );
  seq_model seq (
    .clk_i(clk),
    .rst_i(rst),
    .mc_en_i(mc_en),
    .op_i(op),
    .len_i(len),
    .io_i(io),
    .wd_i(4'h2),
    .req_o(cpu),
    .taken_o(taken)
  );

  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (ack.valid === 1'b1) acks++;

  task automatic complete_run();
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_io(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_io

  task automatic rd_io(input logic [3:0] a, input logic [3:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask : rd_io

  // hazard: a stale taken pulse is skipped by waiting two edges first
  task automatic do_op(input pic_pkg::cpu_op_t o);
    int i;
    @(posedge clk);
    op <= o;
    @(posedge clk);
    #1;
    for (i = 0; i < 24 && taken !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    op <= pic_pkg::OP_NONE;
    check("op taken", taken, 1'b1);
  endtask : do_op

  task automatic wait_ack(input int lvl, input int lim);
    int i;
    i = 0;
    while (ack.valid !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    check("ack level", {ack.valid, ack.level}, {1'b1, lvl[2:0]});
    check("ack vector", ack.vector, vtab[lvl]);
    check("ack active", act[lvl], 1'b1);
  endtask : wait_ack

  function automatic int src_lvl(input int s, input logic [1:0] sel);
    if (s == 4) return sel[0] ? 5 : 1;
    if (s == 5) return sel[0] ? 6 : 2;
    return {sel, (s == 3 || s == 7) ? 1'b0 : 1'b1};
  endfunction : src_lvl

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    int n;
    int s;
    int l;
    logic [1:0] sel;
    logic en;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset state", {pend, act, flags}, 20'h00000);
    for (int a = 0; a < 16; a++) rd_io(a[3:0], 4'h0, "reset read");
    wr_io(`PIC_A_FLAGS, 4'hF);
    wr_io(`PIC_A_ACT_LO, 4'hF);
    wr_io(4'h5, 4'hF);
    rd_io(`PIC_A_FLAGS, 4'h6, "flags bus write");
    rd_io(`PIC_A_ACT_LO, 4'h0, "active write");
    rd_io(4'h5, 4'h0, "unmapped");
    foreach (fop[i]) begin
      do_op(fop[i]);
      check("flags op", flags, fexp[i]);
    end
    @(posedge clk);
    alu_we <= 1'b1;
    alu_c <= 1'b1;
    @(posedge clk);
    alu_we <= 1'b0;
    #1;
    check("flags alu", flags, 4'h4);
    // enable is clear here: requests must only be recorded
    n = acks;
    wr_io(`PIC_A_PEND_LO, 4'hF);
    wr_io(`PIC_A_PEND_HI, 4'hF);
    wr_io(`PIC_A_PEND_LO, 4'h1);
    repeat (12) @(posedge clk);
    check("pending held", {acks[7:0], pend}, {n[7:0], 8'hFF});
    rd_io(`PIC_A_PEND_HI, 4'hF, "pending hi");
    do_op(pic_pkg::OP_IRQ_ON);
    for (l = 7; l >= 0; l--) begin
      wait_ack(l, 10);
      check("active one", act, 8'h01 << l);
      do_op(pic_pkg::OP_RET_IRQ);
      check("retired", {pend >> l, act, flags[0]}, 17'h00001);
    end
    n = acks;
    wr_io(`PIC_A_PEND_LO, 4'h4);
    wait_ack(2, 10);
    wr_io(`PIC_A_PEND_LO, 4'h2);
    repeat (8) @(posedge clk);
    check("lower blocked", acks, n + 1);
    wr_io(`PIC_A_PEND_HI, 4'h2);
    wait_ack(5, 10);
    check("nested active", act, 8'h24);
    do_op(pic_pkg::OP_RET_IRQ);
    repeat (8) @(posedge clk);
    check("after return", {acks[7:0], pend, act}, {n[7:0] + 8'h2, 8'h06, 8'h04});
    do_op(pic_pkg::OP_RET_IRQ);
    wait_ack(1, 10);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset again", {pend, act, flags}, 20'h00000);
    do_op(pic_pkg::OP_IRQ_ON);
    for (n = 0; n < 40; n++) begin
      s = $unsigned($random(seed)) % 8;
      sel = 2'($random(seed));
      en = 1'($random(seed));
      len <= 2'($random(seed));
      wr_io(`PIC_A_CTRL_BASE + s[3:0], {en, 1'b0, sel});
      l = acks;
      @(posedge clk);
      if (s == 2) p60 <= ~p60;
      else if (s == 3) p61 <= ~p61;
      else src[s] <= 1'b1;
      @(posedge clk);
      src <= 8'h00;
      #1;
      if (en) begin
        wait_ack(src_lvl(s, sel), 30);
        do_op(pic_pkg::OP_RET_IRQ);
      end else begin
        repeat (30) @(posedge clk);
        check("masked", {acks[7:0], pend}, {l[7:0], 8'h00});
      end
    end
    len <= 2'h0;
    do_op(pic_pkg::OP_IRQ_OFF);
    wr_io(`PIC_A_CTRL_BASE, 4'h8);
    io <= 1'b1;
    @(posedge clk);
    src[0] <= 1'b1;
    @(posedge clk);
    src[0] <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("io hold", pend, 8'h00);
    io <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("io release", pend, 8'h02);
    do_op(pic_pkg::OP_IRQ_ON);
    wait_ack(1, 10);
    complete_run();
  end
endmodule : priority_interrupt_controller_tb
